// ### fslc_pkg.sv
// fslc_pkg: offsets, field positions, reset values and carrier types for the
// per-framer loopback, elastic store reset, status and interrupt register bank.
// assumes one framer per instance and an 8-bit parallel register port.
package fslc_pkg;

  // register offsets
  localparam logic [7:0] CTL_ADDR         = 8'h0a;
  localparam logic [7:0] STAT_BASE_ADDR   = 8'h20;
  localparam logic [7:0] IRQ_MASK_ONE_ADDR = 8'h16;
  localparam logic [7:0] IRQ_MASK_TWO_ADDR = 8'h17;
  localparam logic [7:0] HDLC_IRQ_MASK_ADDR = 8'h18;
  localparam logic [7:0] SUMMARY_LOW_ADDR = 8'ha0;

  // line_loop_store_control fields
  localparam int unsigned CTL_LOOP_BIT  = 6;
  localparam int unsigned CTL_RXRST_BIT = 5;
  localparam int unsigned CTL_TXRST_BIT = 4;
  localparam logic [7:0]  CTL_WRITABLE  = 8'h70;
  localparam logic [7:0]  CTL_RESET     = 8'h00;

  // status bank: 0 status_reg_one, 1 status_reg_two, 2..4 rx_info_one..three,
  // 5 hdlc_status_reg, 6 facility_link_status, 7..8 further hdlc status
  localparam int unsigned STAT_COUNT = 9;
  localparam logic [3:0]  STAT_NONE     = 4'hf;
  localparam logic [3:0]  STAT_ONE_IDX  = 4'h0;
  localparam logic [3:0]  STAT_TWO_IDX  = 4'h1;
  localparam logic [3:0]  STAT_HDLC_IDX = 4'h5;
  localparam logic [7:0]  STAT_RESET    = 8'h00;
  localparam logic [7:0]  MASK_RESET    = 8'h00;

  // status_reg_one: bit0 rx_yellow_alarm, bit1 rx_carrier_loss/line_carrier_loss,
  // bit2 rx_blue_alarm, bit3 rx_sync_loss, bit4 tx_clock_loss; bits 7..5 events
  localparam logic [7:0] STAT_ONE_ALARM_BITS  = 8'h1f;
  localparam logic [7:0] STAT_ONE_STICKY_BITS = 8'h0f;
  // unlatched bits: bits 2..0 of facility_link_status
  localparam logic [8:0][7:0] STAT_LIVE_BITS = {8'h00, 8'h00, 8'h07, 8'h00,
                                                8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] addr;
    logic [7:0] data;
  } fslc_pins_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } fslc_line_t;

  typedef struct packed {
    logic [8:0][7:0] event_hit;
    logic [8:0][7:0] level;
  } fslc_stat_t;

endpackage

// ### fslc_bank.sv
// fslc_bank: parallel register port, line loopback, elastic store reset
// pulses, nine status registers (latched except bits 2..0 of facility_link_status) and the active-low interrupt.
// assumes port pins and rx line arrive asynchronously; status and formatter
// inputs come from logic on clk_i.
`timescale 1ns/1ps

module fslc_bank #(
  parameter logic [1:0] FRAMER_ID = 2'h0
) (
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire fslc_pkg::fslc_pins_t pins_i,
  output logic [7:0]                data_o,
  output logic                      data_oe_n_o,
  input  wire fslc_pkg::fslc_stat_t stat_i,
  input  wire fslc_pkg::fslc_line_t rx_line_i,
  input  wire fslc_pkg::fslc_line_t fmt_line_i,
  output fslc_pkg::fslc_line_t      rx_line_o,
  output fslc_pkg::fslc_line_t      tx_line_o,
  output logic                      remote_line_loopback_o,
  output logic                      rx_store_depth_reset_o,
  output logic                      tx_store_depth_reset_o,
  output logic                      int_n_o
);

  localparam int unsigned SYNC_W = $bits(fslc_pkg::fslc_pins_t) + $bits(fslc_pkg::fslc_line_t);

  // status register index from a port address
  function automatic logic [3:0] stat_index(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - fslc_pkg::STAT_BASE_ADDR;
    if (addr >= fslc_pkg::STAT_BASE_ADDR && off < 8'(fslc_pkg::STAT_COUNT)) begin
      stat_index = off[3:0];
    end else begin
      stat_index = fslc_pkg::STAT_NONE;
    end
  endfunction

  // three-stage input capture; a change counts once stages two and three agree
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] sync3_r;
  logic [SYNC_W-1:0] filt_r;
  logic [SYNC_W-1:0] filt_nxt;
  fslc_pkg::fslc_pins_t pin_f;
  fslc_pkg::fslc_line_t rx_f;

  assign filt_nxt = (sync3_r & ~(sync2_r ^ sync3_r)) | (filt_r & (sync2_r ^ sync3_r));
  assign pin_f    = filt_r[SYNC_W-1:2];
  assign rx_f     = filt_r[1:0];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_r <= '1;
      sync2_r <= '1;
      sync3_r <= '1;
      filt_r  <= '1;
    end else begin
      sync1_r <= {pins_i, rx_line_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r  <= filt_nxt;
    end
  end

  // strobe edges
  logic       wr_act;
  logic       rd_act;
  logic       wr_act_d_r;
  logic       rd_act_d_r;
  logic       wr_pulse;
  logic       rd_pulse;
  logic [3:0] idx;

  assign wr_act   = ~pin_f.cs_n & ~pin_f.wr_n;
  assign rd_act   = ~pin_f.cs_n & ~pin_f.rd_n;
  assign wr_pulse = wr_act & ~wr_act_d_r;
  assign rd_pulse = rd_act & ~rd_act_d_r;
  assign idx      = stat_index(pin_f.addr);

  // control register and store reset pulses
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic       ctl_wr;
  logic       rxrst_nxt;
  logic       txrst_nxt;
  logic       rxrst_r;
  logic       txrst_r;

  assign ctl_wr    = wr_pulse && pin_f.addr == fslc_pkg::CTL_ADDR;
  assign ctl_nxt   = ctl_wr ? (pin_f.data & fslc_pkg::CTL_WRITABLE) : ctl_r;
  // only a zero-to-one change resets the store; holding the bit high does nothing
  assign rxrst_nxt = ctl_nxt[fslc_pkg::CTL_RXRST_BIT] & ~ctl_r[fslc_pkg::CTL_RXRST_BIT];
  assign txrst_nxt = ctl_nxt[fslc_pkg::CTL_TXRST_BIT] & ~ctl_r[fslc_pkg::CTL_TXRST_BIT];

  // status bank
  logic [8:0][7:0] latch_r;
  logic [8:0][7:0] latch_nxt;
  logic [8:0][7:0] view_r;
  logic [8:0][7:0] view_nxt;
  logic [8:0][7:0] rmask_r;
  logic [8:0][7:0] rmask_nxt;
  logic [8:0][7:0] sticky;

  always_comb begin
    sticky = '0;
    sticky[0] = fslc_pkg::STAT_ONE_STICKY_BITS;
    for (int i = 0; i < 9; i++) begin
      latch_nxt[i] = latch_r[i];
      view_nxt[i]  = view_r[i];
      rmask_nxt[i] = rmask_r[i];
      if (rd_pulse && idx == 4'(i)) begin
        latch_nxt[i] = latch_r[i] & ~(view_r[i] & rmask_r[i]);
      end
      // set wins over the clear in the same cycle
      latch_nxt[i] = latch_nxt[i] | stat_i.event_hit[i];
      latch_nxt[i] = latch_nxt[i] | (stat_i.level[i] & sticky[i]);
      latch_nxt[i] = (latch_nxt[i] & ~fslc_pkg::STAT_LIVE_BITS[i])
                   | (stat_i.level[i] & fslc_pkg::STAT_LIVE_BITS[i]);
      if (wr_pulse && idx == 4'(i)) begin
        view_nxt[i]  = (pin_f.data & latch_r[i]) | (~pin_f.data & view_r[i]);
        rmask_nxt[i] = pin_f.data;
      end
    end
  end

  // interrupt sources: 0 status_reg_one, 1 status_reg_two, 2 hdlc_status_reg
  logic [2:0][7:0] imr_r;
  logic [2:0][7:0] imr_nxt;
  logic [2:0][7:0] pend_r;
  logic [2:0][7:0] pend_nxt;
  logic [7:0]      alarm_prev_r;
  logic [7:0]      alarm_chg;
  logic [2:0][3:0] src_idx;

  assign src_idx   = {fslc_pkg::STAT_HDLC_IDX, fslc_pkg::STAT_TWO_IDX, fslc_pkg::STAT_ONE_IDX};
  assign alarm_chg = (stat_i.level[0] ^ alarm_prev_r) & fslc_pkg::STAT_ONE_ALARM_BITS;

  always_comb begin
    imr_nxt = imr_r;
    if (wr_pulse && pin_f.addr == fslc_pkg::IRQ_MASK_ONE_ADDR) begin
      imr_nxt[0] = pin_f.data;
    end else if (wr_pulse && pin_f.addr == fslc_pkg::IRQ_MASK_TWO_ADDR) begin
      imr_nxt[1] = pin_f.data;
    end else if (wr_pulse && pin_f.addr == fslc_pkg::HDLC_IRQ_MASK_ADDR) begin
      imr_nxt[2] = pin_f.data;
    end
    for (int k = 0; k < 3; k++) begin
      pend_nxt[k] = pend_r[k];
      if (rd_pulse && idx == src_idx[k]) begin
        pend_nxt[k] = pend_r[k] & ~rmask_r[src_idx[k]];
      end
    end
    pend_nxt[0] = pend_nxt[0] | alarm_chg
                | (stat_i.event_hit[0] & ~fslc_pkg::STAT_ONE_ALARM_BITS);
    pend_nxt[1] = pend_nxt[1] | stat_i.event_hit[fslc_pkg::STAT_TWO_IDX];
    pend_nxt[2] = pend_nxt[2] | stat_i.event_hit[fslc_pkg::STAT_HDLC_IDX];
  end

  logic       sr_req;
  logic       hdlc_req;
  logic [7:0] summary;

  assign sr_req   = |(pend_r[0] & imr_r[0]) | |(pend_r[1] & imr_r[1]);
  assign hdlc_req = |(pend_r[2] & imr_r[2]);
  assign summary  = 8'({6'h00, hdlc_req, sr_req} << {FRAMER_ID, 1'b0});

  // readback
  logic [7:0] rd_data;
  logic [7:0] data_r;
  logic       oe_n_r;
  logic       int_n_r;

  always_comb begin
    if (pin_f.addr == fslc_pkg::CTL_ADDR) begin
      rd_data = ctl_r;
    end else if (idx != fslc_pkg::STAT_NONE) begin
      rd_data = view_r[idx];
    end else if (pin_f.addr == fslc_pkg::IRQ_MASK_ONE_ADDR) begin
      rd_data = imr_r[0];
    end else if (pin_f.addr == fslc_pkg::IRQ_MASK_TWO_ADDR) begin
      rd_data = imr_r[1];
    end else if (pin_f.addr == fslc_pkg::HDLC_IRQ_MASK_ADDR) begin
      rd_data = imr_r[2];
    end else if (pin_f.addr >= fslc_pkg::SUMMARY_LOW_ADDR) begin
      rd_data = summary;
    end else begin
      rd_data = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_act_d_r   <= 1'b0;
      rd_act_d_r   <= 1'b0;
      ctl_r        <= fslc_pkg::CTL_RESET;
      rxrst_r      <= 1'b0;
      txrst_r      <= 1'b0;
      latch_r      <= {9{fslc_pkg::STAT_RESET}};
      view_r       <= {9{fslc_pkg::STAT_RESET}};
      rmask_r      <= {9{fslc_pkg::MASK_RESET}};
      imr_r        <= {3{fslc_pkg::MASK_RESET}};
      pend_r       <= '0;
      alarm_prev_r <= 8'h00;
      data_r       <= 8'h00;
      oe_n_r       <= 1'b1;
      int_n_r      <= 1'b1;
    end else begin
      wr_act_d_r   <= wr_act;
      rd_act_d_r   <= rd_act;
      ctl_r        <= ctl_nxt;
      rxrst_r      <= rxrst_nxt;
      txrst_r      <= txrst_nxt;
      latch_r      <= latch_nxt;
      view_r       <= view_nxt;
      rmask_r      <= rmask_nxt;
      imr_r        <= imr_nxt;
      pend_r       <= pend_nxt;
      alarm_prev_r <= stat_i.level[0];
      data_r       <= rd_pulse ? rd_data : data_r;
      oe_n_r       <= ~rd_act;
      int_n_r      <= ~(sr_req | hdlc_req);
    end
  end

  // line path; formatter data is simply not selected during loopback
  fslc_pkg::fslc_line_t tx_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_r <= '0;
    end else begin
      tx_r <= ctl_r[fslc_pkg::CTL_LOOP_BIT] ? rx_f : fmt_line_i;
    end
  end

  assign rx_line_o              = rx_f;
  assign tx_line_o              = tx_r;
  assign remote_line_loopback_o = ctl_r[fslc_pkg::CTL_LOOP_BIT];
  assign rx_store_depth_reset_o = rxrst_r;
  assign tx_store_depth_reset_o = txrst_r;
  assign int_n_o                = int_n_r;
  assign data_o                 = data_r;
  assign data_oe_n_o            = oe_n_r;

endmodule

// ### fslc_bank_chk.sv
// fslc_bank_chk: port assertions for fslc_bank, bound into every instance.
// assumes host strobes stay low well past the port's action edge.
`timescale 1ns/1ps
module fslc_bank_chk (
  input wire logic                 clk_i,
  input wire logic                 rstn_i,
  input wire fslc_pkg::fslc_pins_t pins_i,
  input wire logic [7:0]           data_o,
  input wire logic                 data_oe_n_o,
  input wire fslc_pkg::fslc_stat_t stat_i,
  input wire fslc_pkg::fslc_line_t fmt_line_i,
  input wire fslc_pkg::fslc_line_t rx_line_o,
  input wire fslc_pkg::fslc_line_t tx_line_o,
  input wire logic                 remote_line_loopback_o,
  input wire logic                 rx_store_depth_reset_o,
  input wire logic                 tx_store_depth_reset_o,
  input wire logic                 int_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire ctl_wr = !pins_i.cs_n && !pins_i.wr_n && pins_i.addr == fslc_pkg::CTL_ADDR;
  wire rd_on = !pins_i.cs_n && !pins_i.rd_n;
  wire [4:0] alm = stat_i.level[0][4:0];
  a_loop_tx_path: assert property ((remote_line_loopback_o && $stable(rx_line_o))[*3]
    |-> tx_line_o == rx_line_o) else $error("loopback data wrong");
  a_fmt_pass: assert property ((!remote_line_loopback_o && $stable(fmt_line_i))[*2]
    |-> tx_line_o == fmt_line_i) else $error("formatter data wrong");
  a_rx_store_pulse: assert property (rx_store_depth_reset_o |->
    ctl_wr && pins_i.data[5] ##1 !rx_store_depth_reset_o) else $error("rx pulse wrong");
  a_tx_store_pulse: assert property (tx_store_depth_reset_o |->
    ctl_wr && pins_i.data[4] ##1 !tx_store_depth_reset_o) else $error("tx pulse wrong");
  a_loop_follows: assert property ($changed(remote_line_loopback_o) |->
    ctl_wr && remote_line_loopback_o == pins_i.data[6]) else $error("loopback change wrong");
  a_ctl_read_back: assert property ($fell(data_oe_n_o) && pins_i.addr == 8'h0a |->
    (data_o & 8'h8f) == 8'h00 && data_o[6] == remote_line_loopback_o)
    else $error("control readback wrong");
  a_int_release: assert property ($rose(int_n_o) |-> rd_on)
    else $error("interrupt released without read");
  a_int_cause: assert property ($fell(int_n_o) |-> $past(stat_i.event_hit, 2) != '0
    || $past(alm, 2) != $past(alm, 3) || $past(alm, 3) != $past(alm, 4))
    else $error("interrupt without cause");
  cover property (rx_store_depth_reset_o);
  cover property ($fell(int_n_o));
  cover property ($fell(remote_line_loopback_o));
endmodule
bind fslc_bank fslc_bank_chk chk_u (.clk_i(clk_i), .rstn_i(rstn_i), .pins_i(pins_i),
  .data_o(data_o), .data_oe_n_o(data_oe_n_o), .stat_i(stat_i), .fmt_line_i(fmt_line_i),
  .rx_line_o(rx_line_o), .tx_line_o(tx_line_o), .int_n_o(int_n_o),
  .remote_line_loopback_o(remote_line_loopback_o),
  .rx_store_depth_reset_o(rx_store_depth_reset_o),
  .tx_store_depth_reset_o(tx_store_depth_reset_o));

// ### fslc_host.sv
// fslc_host: behavioural controller on the parallel register port.
// assumes the port acts 5 edges after a strobe and wants 3 idle between.
`timescale 1ns/1ps
module fslc_host (
  input  wire logic            clk_i,
  input  wire logic [7:0]      data_i,
  output fslc_pkg::fslc_pins_t pins_o
);
  initial pins_o = '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00};
  task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_i);
    pins_o.addr <= a;
    pins_o.data <= d;
    repeat (6) @(posedge clk_i);
    pins_o.cs_n <= 1'b0;
    pins_o.rd_n <= !rd;
    pins_o.wr_n <= rd;
    // held 8 edges so the answer is settled when taken
    repeat (8) @(posedge clk_i);
    q = data_i;
    pins_o.cs_n <= 1'b1;
    pins_o.rd_n <= 1'b1;
    pins_o.wr_n <= 1'b1;
    pins_o.data <= ~d;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] q);
    logic [7:0] x;
    acc(1'b0, a, m, x);
    acc(1'b1, a, 8'h00, q);
    acc(1'b0, a, q & m, x);
  endtask
endmodule

// ### framer_status_loopback_ctrl_test.sv
// framer_status_loopback_ctrl_test: drives fslc_bank through fslc_host and
// its line and status inputs; a monitor checks each read against queued notes.
`timescale 1ns/1ps
module framer_status_loopback_ctrl_test;
  logic                      clk_i = 1'b0;
  logic                      rstn_i = 1'b0;
  wire fslc_pkg::fslc_pins_t pins_i;
  fslc_pkg::fslc_stat_t      stat_i = '0;
  fslc_pkg::fslc_line_t      rx_line_i = '0;
  fslc_pkg::fslc_line_t      fmt_line_i = '0;
  fslc_pkg::fslc_line_t      rx_line_o, tx_line_o;
  logic [7:0]                data_o, q, exp_q[$];
  logic                      oe_n, oe_q = 1'b1, loop, rxp, txp, int_n;
  int                        bad_count = 0, checks = 0, rx_n = 0, tx_n = 0;
  always #5 clk_i = ~clk_i;
  fslc_bank dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .pins_i(pins_i), .data_o(data_o),
    .data_oe_n_o(oe_n), .stat_i(stat_i), .rx_line_i(rx_line_i), .fmt_line_i(fmt_line_i),
    .rx_line_o(rx_line_o), .tx_line_o(tx_line_o), .remote_line_loopback_o(loop),
    .rx_store_depth_reset_o(rxp), .tx_store_depth_reset_o(txp), .int_n_o(int_n));
  fslc_host h_u (.clk_i(clk_i), .data_i(data_o), .pins_o(pins_i));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // a read answer is compared one edge after the output enable falls
  always @(posedge clk_i) begin
    oe_q <= oe_n;
    if (rxp === 1'b1) rx_n++;
    if (txp === 1'b1) tx_n++;
    if (oe_q === 1'b1 && oe_n === 1'b0)
      chk("read", exp_q.size() ? exp_q.pop_front() : 8'hxx, data_o);
  end
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    h_u.acc(1'b1, a, 8'h00, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    h_u.acc(1'b0, a, d, q);
  endtask
  task automatic sp(input logic [3:0] i, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back(e);
    h_u.poll(fslc_pkg::STAT_BASE_ADDR + 8'(i), m, q);
  endtask
  task automatic ev(input int r, input int b);
    stat_i.event_hit <= 72'h1 << (8 * r + b);
    @(posedge clk_i);
    stat_i.event_hit <= '0;
  endtask
  task automatic ci(input logic e);
    repeat (4) @(posedge clk_i);
    chk("int_n", {7'h00, e}, {7'h00, int_n});
  endtask
  initial begin
    fslc_pkg::fslc_line_t v;
    void'($urandom(32'h7fbb));
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(fslc_pkg::CTL_ADDR, fslc_pkg::CTL_RESET);
    rd(8'h05, 8'h00);
    wr(fslc_pkg::CTL_ADDR, 8'h60);
    rd(fslc_pkg::CTL_ADDR, 8'h60);
    chk("loopback", 8'h01, {7'h00, loop});
    repeat (4) begin
      v = 2'($urandom);
      rx_line_i <= v;
      fmt_line_i <= ~v;
      repeat (12) @(posedge clk_i);
      chk("tx_line", {6'h00, v}, {6'h00, tx_line_o});
      chk("rx_line", {6'h00, v}, {6'h00, rx_line_o});
    end
    wr(fslc_pkg::CTL_ADDR, 8'h50);
    wr(fslc_pkg::CTL_ADDR, 8'h00);
    chk("loopback", 8'h00, {7'h00, loop});
    v = 2'($urandom);
    fmt_line_i <= v;
    repeat (4) @(posedge clk_i);
    chk("fmt_pass", {6'h00, v}, {6'h00, tx_line_o});
    chk("rx_pulses", 8'h01, 8'(rx_n));
    chk("tx_pulses", 8'h01, 8'(tx_n));
    wr(fslc_pkg::IRQ_MASK_ONE_ADDR, 8'h84);
    wr(fslc_pkg::IRQ_MASK_TWO_ADDR, 8'h01);
    wr(fslc_pkg::HDLC_IRQ_MASK_ADDR, 8'h01);
    ev(0, 5);
    ci(1'b1);
    ev(0, 7);
    ci(1'b0);
    rd(8'ha0 + 8'($urandom_range(95)), 8'h01);
    sp(0, 8'h80, 8'h80);
    ci(1'b1);
    sp(0, 8'h80, 8'h00);
    stat_i.level[0][2] <= 1'b1;
    ci(1'b0);
    sp(0, 8'h00, 8'h00);
    ci(1'b0);
    sp(0, 8'h04, 8'h04);
    ci(1'b1);
    sp(0, 8'h04, 8'h04);
    stat_i.level[0][2] <= 1'b0;
    ci(1'b0);
    sp(0, 8'h24, 8'h24);
    ci(1'b1);
    sp(0, 8'h04, 8'h00);
    ev(1, 0);
    ci(1'b0);
    rd(8'hff, 8'h01);
    sp(1, 8'h01, 8'h01);
    ci(1'b1);
    ev(5, 0);
    ci(1'b0);
    rd(8'ha0 + 8'($urandom_range(95)), 8'h02);
    sp(5, 8'h01, 8'h01);
    ci(1'b1);
    ev(2, 3);
    ci(1'b1);
    sp(2, 8'h08, 8'h08);
    stat_i.level[6][1] <= 1'b1;
    sp(6, 8'h02, 8'h02);
    stat_i.level[6][1] <= 1'b0;
    sp(6, 8'h02, 8'h00);
    chk("queue", 8'h00, 8'(exp_q.size()));
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    conclude();
  end
endmodule
